// file: light_sensor_i2c_register_control.sv
// two-wire register slave and converter timing control of the light sensor
`timescale 1ns/10ps
`include "light_sensor_params.svh"

module light_sensor_i2c_register_control (
   input wire logic clk,
   input wire logic nrst,
   input wire logic osc_clk,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input wire logic address_select_pin,
   input wire logic balance_pulse,
   output logic converter_reset,
   output logic converter_power_down,
   output logic [1:0] range_select,
   output logic interrupt_clear
);
   light_sensor_pkg::bus_state_t s;
   light_sensor_pkg::bus_state_t next_s;
   light_sensor_pkg::osc_state_t o;
   light_sensor_pkg::osc_state_t next_o;

   // ----------------------------------------
   // bus line events
   // ----------------------------------------
   logic scl_rise;
   logic scl_fall;
   logic bus_start;
   logic bus_stop;
   logic byte_end;
   logic done_ev;
   logic [7:0] rd;
   assign scl_rise = s.scl_s[1] & ~s.scl_s[2];
   assign scl_fall = ~s.scl_s[1] & s.scl_s[2];
   assign bus_start = s.scl_s[1] & s.scl_s[2] & ~s.sda_s[1] & s.sda_s[2];
   assign bus_stop = s.scl_s[1] & s.scl_s[2] & s.sda_s[1] & ~s.sda_s[2];
   assign byte_end = scl_fall && (s.bit_cnt == `BYTE_BITS);
   assign done_ev = s.done_s[2] ^ s.done_s[1];

   always_comb begin
      unique case (s.ptr)
         `REG_CMD: rd = s.cmd;
         `REG_CTRL: rd = s.ctrl;
         `REG_THR_LO: rd = s.thr_lo;
         `REG_THR_HI: rd = s.thr_hi;
         `REG_LIGHT_LO: rd = s.light[7:0];
         `REG_LIGHT_HI: rd = s.light[15:8];
         `REG_CYC_LO: rd = s.cycles[7:0];
         `REG_CYC_HI: rd = s.cycles[15:8];
      endcase
   end

   // ----------------------------------------
   // bus slave and register file
   // ----------------------------------------
   always_comb begin
      next_s = s;
      next_s.scl_s = {s.scl_s[1:0], scl_in};
      next_s.sda_s = {s.sda_s[1:0], sda_in};
      next_s.a0_s1 = address_select_pin;
      next_s.a0_s2 = s.a0_s1;
      next_s.done_s = {s.done_s[1:0], o.done_tgl};
      next_s.int_clear = 1'b0;
      next_s.sda_o = 1'b0;
      if (done_ev) begin
         next_s.light = o.light_res;
         next_s.cycles = o.cyc_res;
      end
      if (scl_rise) begin
         next_s.bit_cnt = s.bit_cnt + 4'h1;
      end
      if (bus_stop) begin
         next_s.st = light_sensor_pkg::ST_IDLE;
         next_s.sda_oe = 1'b0;
      end else if (bus_start) begin
         next_s.st = light_sensor_pkg::ST_ADDR;
         next_s.bit_cnt = 4'h0;
         next_s.sda_oe = 1'b0;
      end else begin
         unique case (s.st)
            light_sensor_pkg::ST_IDLE: begin
            end
            light_sensor_pkg::ST_ADDR, light_sensor_pkg::ST_REG,
            light_sensor_pkg::ST_WDATA: begin
               if (scl_rise) begin
                  next_s.shift = {s.shift[6:0], s.sda_s[1]};
               end
               if (byte_end) begin
                  next_s.sda_oe = 1'b1;
                  if (s.st == light_sensor_pkg::ST_ADDR) begin
                     if (s.shift[7:1] == {`SLAVE_ADDR_HI, s.a0_s2}) begin
                        next_s.st = light_sensor_pkg::ST_AACK;
                        next_s.rw = s.shift[0];
                     end else begin
                        next_s.st = light_sensor_pkg::ST_IDLE;
                        next_s.sda_oe = 1'b0;
                     end
                  end else if (s.st == light_sensor_pkg::ST_REG) begin
                     next_s.st = light_sensor_pkg::ST_RACK;
                     next_s.ptr = s.shift[2:0];
                     if (s.shift[`PTR_SYNC_BIT] && s.cmd[`CMD_EXT_BIT]) begin
                        next_s.sync_tgl = ~s.sync_tgl;
                     end
                     next_s.int_clear = s.shift[`PTR_CLR_BIT];
                  end else begin
                     next_s.st = light_sensor_pkg::ST_WACK;
                     next_s.ptr = s.ptr + 3'h1;
                     unique case (s.ptr)
                        `REG_CMD: next_s.cmd = s.shift & `CMD_MASK;
                        `REG_CTRL: next_s.ctrl = s.shift & `CTRL_MASK;
                        `REG_THR_LO: next_s.thr_lo = s.shift;
                        `REG_THR_HI: next_s.thr_hi = s.shift;
                        default: begin
                        end
                     endcase
                  end
               end
            end
            light_sensor_pkg::ST_AACK: begin
               if (scl_fall) begin
                  next_s.bit_cnt = 4'h0;
                  if (s.rw) begin
                     next_s.st = light_sensor_pkg::ST_RDATA;
                     next_s.shift = rd;
                     next_s.sda_oe = ~rd[7];
                  end else begin
                     next_s.st = light_sensor_pkg::ST_REG;
                     next_s.sda_oe = 1'b0;
                  end
               end
            end
            light_sensor_pkg::ST_RACK, light_sensor_pkg::ST_WACK: begin
               if (scl_fall) begin
                  next_s.st = light_sensor_pkg::ST_WDATA;
                  next_s.bit_cnt = 4'h0;
                  next_s.sda_oe = 1'b0;
               end
            end
            light_sensor_pkg::ST_RDATA: begin
               if (byte_end) begin
                  next_s.st = light_sensor_pkg::ST_MACK;
                  next_s.sda_oe = 1'b0;
                  next_s.ptr = s.ptr + 3'h1;
               end else if (scl_fall) begin
                  next_s.shift = {s.shift[6:0], 1'b0};
                  next_s.sda_oe = ~s.shift[6];
               end
            end
            light_sensor_pkg::ST_MACK: begin
               if (scl_rise) begin
                  next_s.nack = s.sda_s[1];
               end
               if (scl_fall) begin
                  next_s.bit_cnt = 4'h0;
                  if (s.nack) begin
                     next_s.st = light_sensor_pkg::ST_IDLE;
                  end else begin
                     next_s.st = light_sensor_pkg::ST_RDATA;
                     next_s.shift = rd;
                     next_s.sda_oe = ~rd[7];
                  end
               end
            end
         endcase
      end
      next_s.conv_reset = ~s.cmd[`CMD_RUN_BIT];
      next_s.power_down = s.cmd[`CMD_PD_BIT];
      next_s.range = s.ctrl[`CTRL_RANGE_HI:`CTRL_RANGE_LO];
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         s <= '0;
         s.st <= light_sensor_pkg::ST_IDLE;
         // bus lines idle high, so no false edge follows reset
         s.scl_s <= `LINE_IDLE;
         s.sda_s <= `LINE_IDLE;
      end else begin
         s <= next_s;
      end
   end

   assign sda_out = s.sda_o;
   assign sda_oe = s.sda_oe;
   assign converter_reset = s.conv_reset;
   assign converter_power_down = s.power_down;
   assign range_select = s.range;
   assign interrupt_clear = s.int_clear;

   // ----------------------------------------
   // converter timing on the oscillator clock
   // ----------------------------------------
   light_sensor_pkg::cfg_t c;
   logic active;
   logic sync_ev;
   logic [15:0] last;
   logic [15:0] cmax;
   assign c = o.cfg_s2;
   assign active = c.run & ~c.pd & (c.mode == `MODE_LIGHT);
   assign sync_ev = o.sync_s[2] ^ o.sync_s[1];

   always_comb begin
      unique case (c.width)
         2'h0: begin
            last = `LAST_W16;
            cmax = `MAX_W16;
         end
         2'h1: begin
            last = `LAST_W12;
            cmax = `MAX_W12;
         end
         2'h2: begin
            last = `LAST_W8;
            cmax = `MAX_W8;
         end
         2'h3: begin
            last = `LAST_W4;
            cmax = `MAX_W4;
         end
      endcase
   end

   always_comb begin
      next_o = o;
      next_o.cfg_s1 = {s.cmd[`CMD_RUN_BIT], s.cmd[`CMD_PD_BIT], s.cmd[`CMD_EXT_BIT],
                       s.cmd[`CMD_MODE_HI:`CMD_MODE_LO], s.cmd[`CMD_WIDTH_HI:`CMD_WIDTH_LO]};
      next_o.cfg_s2 = o.cfg_s1;
      next_o.sync_s = {o.sync_s[1:0], s.sync_tgl};
      if (!active) begin
         next_o.cycles = 16'h0000;
         next_o.count = 16'h0000;
      end else if (c.ext ? sync_ev : (o.cycles == last)) begin
         next_o.light_res = o.count;
         next_o.cyc_res = o.cycles;
         next_o.done_tgl = ~o.done_tgl;
         next_o.cycles = 16'h0000;
         next_o.count = 16'h0000;
      end else begin
         next_o.cycles = o.cycles + 16'h0001;
         if (balance_pulse && (o.count < cmax)) begin
            next_o.count = o.count + 16'h0001;
         end
      end
   end

   always_ff @(posedge osc_clk or negedge nrst) begin
      if (!nrst) begin
         o <= '0;
      end else begin
         o <= next_o;
      end
   end

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   AST_CMD_HOLD: assert property (@(posedge clk) disable iff (!nrst)
      !(byte_end && s.st == light_sensor_pkg::ST_WDATA && s.ptr == `REG_CMD) |=> $stable(s.cmd))
      else $error("command register changed without a write");
   AST_RO_KEEP: assert property (@(posedge clk) disable iff (!nrst)
      !done_ev |=> $stable(s.light) && $stable(s.cycles))
      else $error("read-only data changed without a result");
   AST_ADDR_MATCH: assert property (@(posedge clk) disable iff (!nrst)
      $rose(s.st == light_sensor_pkg::ST_AACK) |-> s.shift[7:1] == {`SLAVE_ADDR_HI, $past(s.a0_s2)})
      else $error("acknowledged a foreign address");
   AST_ADDR_ACCEPT: assert property (@(posedge clk) disable iff (!nrst)
      byte_end && !bus_stop && !bus_start && s.st == light_sensor_pkg::ST_ADDR
      && s.shift[7:1] == {`SLAVE_ADDR_HI, s.a0_s2} |=> s.st == light_sensor_pkg::ST_AACK && s.sda_oe)
      else $error("own address not acknowledged");
   AST_ACK_LOW: assert property (@(posedge clk) disable iff (!nrst)
      s.st inside {light_sensor_pkg::ST_AACK, light_sensor_pkg::ST_RACK, light_sensor_pkg::ST_WACK}
      |-> s.sda_oe && !s.sda_o)
      else $error("data line not held low in acknowledge");
   AST_SYNC: assert property (@(posedge clk) disable iff (!nrst)
      byte_end && !bus_stop && !bus_start && s.st == light_sensor_pkg::ST_REG
      && s.shift[`PTR_SYNC_BIT] && s.cmd[`CMD_EXT_BIT] |=> s.sync_tgl != $past(s.sync_tgl))
      else $error("sync command not forwarded");
   AST_CLR: assert property (@(posedge clk) disable iff (!nrst)
      byte_end && !bus_stop && !bus_start && s.st == light_sensor_pkg::ST_REG
      && s.shift[`PTR_CLR_BIT] |=> s.int_clear ##1 !s.int_clear)
      else $error("interrupt clear pulse missing");
   AST_IDLE_RESET: assert property (@(posedge osc_clk) disable iff (!nrst)
      !active |=> o.cycles == 16'h0000 && o.count == 16'h0000)
      else $error("converter counters run while disabled");
   AST_INT_END: assert property (@(posedge osc_clk) disable iff (!nrst)
      active && !c.ext && o.cycles == last |=> o.cycles == 16'h0000 && o.done_tgl != $past(o.done_tgl))
      else $error("internal integration did not end on time");
   AST_EXT_CAP: assert property (@(posedge osc_clk) disable iff (!nrst)
      active && c.ext && sync_ev |=> o.cyc_res == $past(o.cycles) && o.cycles == 16'h0000)
      else $error("external cycle count not captured");
   AST_SATURATE: assert property (@(posedge osc_clk) disable iff (!nrst)
      active && o.count >= cmax && !(c.ext ? sync_ev : (o.cycles == last))
      |=> o.count == $past(o.count))
      else $error("light count passed its signed limit");
   AST_RUN_PIN: assert property (@(posedge clk) disable iff (!nrst)
      1'b1 |=> s.conv_reset == !$past(s.cmd[`CMD_RUN_BIT]))
      else $error("converter reset does not follow the run bit");
   AST_PD_PIN: assert property (@(posedge clk) disable iff (!nrst)
      1'b1 |=> s.power_down == $past(s.cmd[`CMD_PD_BIT]))
      else $error("power down does not follow its command bit");
   AST_RANGE_PIN: assert property (@(posedge clk) disable iff (!nrst)
      1'b1 |=> s.range == $past(s.ctrl[`CTRL_RANGE_HI:`CTRL_RANGE_LO]))
      else $error("range select does not follow the range register");
   AST_RESULT_LOAD: assert property (@(posedge clk) disable iff (!nrst)
      done_ev |=> s.light == $past(o.light_res) && s.cycles == $past(o.cyc_res))
      else $error("finished result not loaded into the data registers");
   AST_PTR_INC: assert property (@(posedge clk) disable iff (!nrst)
      byte_end && !bus_stop && !bus_start && s.st == light_sensor_pkg::ST_WDATA
      |=> s.ptr == $past(s.ptr) + 3'h1)
      else $error("pointer did not advance after a data byte");
   AST_WR_DATA: assert property (@(posedge clk) disable iff (!nrst)
      byte_end && !bus_stop && !bus_start && s.st == light_sensor_pkg::ST_WDATA
      && s.ptr == `REG_THR_LO |=> s.thr_lo == $past(s.shift))
      else $error("written byte not stored");
   COV_WRITE: cover property (@(posedge clk) disable iff (!nrst)
      $rose(s.st == light_sensor_pkg::ST_WACK));
   COV_READ: cover property (@(posedge clk) disable iff (!nrst)
      $rose(s.st == light_sensor_pkg::ST_MACK));
   COV_RESULT: cover property (@(posedge clk) disable iff (!nrst) done_ev);
   COV_EXT_SYNC: cover property (@(posedge osc_clk) disable iff (!nrst) active && c.ext && sync_ev);
   COV_CLEAR: cover property (@(posedge clk) disable iff (!nrst) s.int_clear);
endmodule : light_sensor_i2c_register_control

// file: light_sensor_params.svh
// constants for the light sensor register and conversion control
`ifndef LIGHT_SENSOR_PARAMS_SVH
`define LIGHT_SENSOR_PARAMS_SVH
`define REG_CMD 3'h0
`define REG_CTRL 3'h1
`define REG_THR_LO 3'h2
`define REG_THR_HI 3'h3
`define REG_LIGHT_LO 3'h4
`define REG_LIGHT_HI 3'h5
`define REG_CYC_LO 3'h6
`define REG_CYC_HI 3'h7
`define REG_RESET 8'h00
`define LINE_IDLE 3'h7
`define CMD_MASK 8'hEF
`define CTRL_MASK 8'h0C
`define SLAVE_ADDR_HI 6'h22
`define PTR_SYNC_BIT 7
`define PTR_CLR_BIT 6
`define CMD_RUN_BIT 7
`define CMD_PD_BIT 6
`define CMD_EXT_BIT 5
`define CMD_MODE_HI 3
`define CMD_MODE_LO 2
`define CMD_WIDTH_HI 1
`define CMD_WIDTH_LO 0
`define CTRL_RANGE_HI 3
`define CTRL_RANGE_LO 2
`define MODE_LIGHT 2'h2
`define BYTE_BITS 4'h8
`define LAST_W16 16'hFFFF
`define LAST_W12 16'h0FFF
`define LAST_W8 16'h00FF
`define LAST_W4 16'h000F
`define MAX_W16 16'h7FFF
`define MAX_W12 16'h07FF
`define MAX_W8 16'h007F
`define MAX_W4 16'h0007
`endif

// file: light_sensor_pkg.sv
// types of the light sensor register and conversion control
package light_sensor_pkg;
   typedef enum logic [8:0] {
      ST_IDLE = 9'h001,
      ST_ADDR = 9'h002,
      ST_AACK = 9'h004,
      ST_REG = 9'h008,
      ST_RACK = 9'h010,
      ST_WDATA = 9'h020,
      ST_WACK = 9'h040,
      ST_RDATA = 9'h080,
      ST_MACK = 9'h100
   } bus_st_t;

   typedef struct packed {
      logic run;
      logic pd;
      logic ext;
      logic [1:0] mode;
      logic [1:0] width;
   } cfg_t;

   typedef struct packed {
      logic [2:0] scl_s;
      logic [2:0] sda_s;
      logic a0_s1;
      logic a0_s2;
      bus_st_t st;
      logic [3:0] bit_cnt;
      logic [7:0] shift;
      logic rw;
      logic nack;
      logic [2:0] ptr;
      logic [7:0] cmd;
      logic [7:0] ctrl;
      logic [7:0] thr_lo;
      logic [7:0] thr_hi;
      logic [15:0] light;
      logic [15:0] cycles;
      logic [2:0] done_s;
      logic sync_tgl;
      logic int_clear;
      logic sda_oe;
      logic sda_o;
      logic conv_reset;
      logic power_down;
      logic [1:0] range;
   } bus_state_t;

   typedef struct packed {
      cfg_t cfg_s1;
      cfg_t cfg_s2;
      logic [2:0] sync_s;
      logic [15:0] cycles;
      logic [15:0] count;
      logic [15:0] light_res;
      logic [15:0] cyc_res;
      logic done_tgl;
   } osc_state_t;
endpackage : light_sensor_pkg

// file: i2c_host_model.sv
// two-wire bus master model driving the sensor's serial pins
`timescale 1ns/10ps
module i2c_host_model (
   input wire logic clk,
   input wire logic sda,
   output logic scl,
   output logic sda_drv
);
   // ----------------------------------------
   // bus cycles, half bit period of 12 clocks
   // ----------------------------------------
   initial begin
      scl = 1'b1;
      sda_drv = 1'b1;
   end
   task automatic hold(input int n);
      repeat (n) @(negedge clk);
   endtask : hold
   task automatic start;
      sda_drv = 1'b1;
      scl = 1'b1;
      hold(12);
      sda_drv = 1'b0;
      hold(12);
      scl = 1'b0;
      hold(6);
   endtask : start
   task automatic stop;
      sda_drv = 1'b0;
      hold(6);
      scl = 1'b1;
      hold(12);
      sda_drv = 1'b1;
      hold(12);
   endtask : stop
   task automatic clk_bit(input logic b, output logic q);
      sda_drv = b;
      hold(6);
      scl = 1'b1;
      hold(6);
      q = sda;
      hold(6);
      scl = 1'b0;
      hold(6);
   endtask : clk_bit
   task automatic wbyte(input logic [7:0] d, output logic ack);
      logic q;
      for (int i = 7; i >= 0; i--) clk_bit(d[i], q);
      clk_bit(1'b1, q);
      ack = ~q;
   endtask : wbyte
   task automatic rbyte(input logic last, output logic [7:0] d);
      logic q;
      for (int i = 7; i >= 0; i--) clk_bit(1'b1, d[i]);
      clk_bit(last, q);
   endtask : rbyte
endmodule : i2c_host_model

// file: tb.sv
// self-checking bench for the light sensor register and conversion control
`timescale 1ns/10ps
`include "light_sensor_params.svh"
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin failures++; \
   $display("mismatch %s expected %h seen %h", nm, ex, got); end end
module tb;
   // ----------------------------------------
   // signals and instances
   // ----------------------------------------
   logic clk, osc_clk, nrst, a0, bp, scl, h_sda, sda_out, sda_oe, conv_rst, pd, iclr, ack;
   logic [1:0] rng;
   logic [15:0] d;
   logic [7:0] rdat [8];
   int failures = 0, tests_run = 0, cyc = 0, ic_n = 0, ic_a = 0, ic_b = 0, e;
   wire logic sda_w;
   // pull-up on the data wire
   assign sda_w = h_sda & ~(sda_oe & ~sda_out);
   light_sensor_i2c_register_control i_light_sensor_i2c_register_control (
      .clk(clk), .nrst(nrst), .osc_clk(osc_clk), .scl_in(scl), .sda_in(sda_w),
      .sda_out(sda_out), .sda_oe(sda_oe), .address_select_pin(a0), .balance_pulse(bp),
      .converter_reset(conv_rst), .converter_power_down(pd), .range_select(rng),
      .interrupt_clear(iclr));
   i2c_host_model i_i2c_host_model (.clk(clk), .sda(sda_w), .scl(scl), .sda_drv(h_sda));
   // ----------------------------------------
   // clocks and monitors
   // ----------------------------------------
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   initial begin
      osc_clk = 1'b0;
      #3;
      forever #16 osc_clk = ~osc_clk;
   end
   always @(negedge osc_clk) bp <= ($urandom_range(7, 0) != 0);
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (iclr === 1'b1) begin
         ic_n <= ic_n + 1;
         ic_b <= ic_a;
         ic_a <= cyc;
      end
   end
   initial begin
      repeat (100000) @(posedge clk);
      failures++;
      report_and_stop();
   end
   // ----------------------------------------
   // expectations and bus tasks
   // ----------------------------------------
   function automatic logic [15:0] exp_last(input logic [1:0] w);
      return (16'h1 << (5'd16 - 5'd4 * w)) - 16'h1;
   endfunction : exp_last
   function automatic logic [15:0] exp_max(input logic [1:0] w);
      return (16'h1 << (5'd15 - 5'd4 * w)) - 16'h1;
   endfunction : exp_max
   task automatic wr(input logic [7:0] ptr, input logic [7:0] dat, input logic with_dat);
      i_i2c_host_model.start();
      i_i2c_host_model.wbyte({`SLAVE_ADDR_HI, a0, 1'b0}, ack);
      `CHK("addr_ack", 1'b1, ack)
      i_i2c_host_model.wbyte(ptr, ack);
      `CHK("ptr_ack", 1'b1, ack)
      if (with_dat) begin
         i_i2c_host_model.wbyte(dat, ack);
         `CHK("data_ack", 1'b1, ack)
      end
      i_i2c_host_model.stop();
   endtask : wr
   task automatic rd(input logic [7:0] ptr, input int n);
      wr(ptr, 8'h00, 1'b0);
      i_i2c_host_model.start();
      i_i2c_host_model.wbyte({`SLAVE_ADDR_HI, a0, 1'b1}, ack);
      for (int i = 0; i < n; i++) i_i2c_host_model.rbyte(i == n - 1, rdat[i]);
      i_i2c_host_model.stop();
   endtask : rd
   task automatic report_and_stop;
      $display("checks %0d failures %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : report_and_stop
   // ----------------------------------------
   // tests
   // ----------------------------------------
   initial begin
      void'($urandom(32'h4BA7E2C7));
      nrst = 1'b0;
      a0 = 1'b0;
      repeat (20) @(negedge clk);
      nrst = 1'b1;
      repeat (6) @(negedge clk);
      `CHK("conv_reset", 1'b1, conv_rst)
      rd(8'h00, 8);
      for (int i = 0; i < 8; i++) `CHK("reset_value", 8'h00, rdat[i])
      for (int p = 0; p < 2; p++) begin
         a0 = p[0];
         repeat (4) @(negedge clk);
         for (int s = 0; s < 2; s++) begin
            i_i2c_host_model.start();
            i_i2c_host_model.wbyte({`SLAVE_ADDR_HI, s[0], 1'b0}, ack);
            `CHK("addr_match", (s == p), ack)
            i_i2c_host_model.stop();
         end
      end
      a0 = 1'b0;
      repeat (4) @(negedge clk);
      for (int r = 0; r < 3; r++) begin
         logic [7:0] c, k, t0, t1;
         // diode select kept off so the result bytes stay still
         c = (r == 0) ? 8'hF7 : (8'($urandom()) & 8'hF7);
         k = (r == 0) ? 8'hFF : 8'($urandom());
         t0 = 8'($urandom());
         t1 = 8'($urandom());
         wr(8'h00, c, 1'b1);
         wr(8'h01, k, 1'b1);
         wr(8'h02, t0, 1'b1);
         wr(8'h03, t1, 1'b1);
         wr(8'h04, 8'h5A, 1'b1);
         rd(8'h00, 5);
         `CHK("cmd", c & `CMD_MASK, rdat[0])
         `CHK("ctrl", k & `CTRL_MASK, rdat[1])
         `CHK("thr_lo", t0, rdat[2])
         `CHK("thr_hi", t1, rdat[3])
         `CHK("ro_light", 8'h00, rdat[4])
         `CHK("range_pin", k[3:2], rng)
         `CHK("pd_pin", c[6], pd)
         `CHK("reset_pin", ~c[7], conv_rst)
      end
      for (int w = 3; w > 0; w--) begin
         wr(8'h00, {6'h22, w[1:0]}, 1'b1);
         repeat (8 * (int'(exp_last(w[1:0])) + 1) + 200) @(negedge clk);
         rd(8'h04, 4);
         `CHK("light", exp_max(w[1:0]), {rdat[1], rdat[0]})
         `CHK("cycles", exp_last(w[1:0]), {rdat[3], rdat[2]})
      end
      for (int h = 0; h < 2; h++) begin
         // diode code 11, then power down: the last result must stay
         wr(8'h00, (h == 0) ? 8'h8F : 8'hCB, 1'b1);
         repeat (300) @(negedge clk);
         rd(8'h04, 4);
         `CHK("held_light", exp_max(2'h1), {rdat[1], rdat[0]})
         `CHK("held_cycles", exp_last(2'h1), {rdat[3], rdat[2]})
      end
      wr(8'h00, 8'hAB, 1'b1);
      repeat (300) @(negedge clk);
      wr(8'hC0, 8'h00, 1'b0);
      repeat (200 + $urandom_range(600, 0)) @(negedge clk);
      wr(8'hC0, 8'h00, 1'b0);
      repeat (50) @(negedge clk);
      `CHK("clear_pulses", 2, ic_n)
      rd(8'h04, 4);
      d = {rdat[3], rdat[2]};
      e = ic_a - ic_b - 4 * int'(d);
      `CHK("ext_light", 16'h0007, {rdat[1], rdat[0]})
      `CHK("ext_cycles", 1'b1, (e >= -16) && (e <= 16))
      wr(8'h80, 8'h00, 1'b0);
      repeat (50) @(negedge clk);
      `CHK("clear_only_bit6", 2, ic_n)
      report_and_stop();
   end
endmodule : tb
